// >>> hdl/detail_defs.svh
`ifndef DETAIL_DEFS_SVH
`define DETAIL_DEFS_SVH
// ----------------------------------------------------------------
// register map (word offsets as byte addresses)
// ----------------------------------------------------------------
`define REG_CTRL        8'h00
`define REG_OFFSET      8'h04
`define REG_LIMITS      8'h08
`define REG_SURF        8'h0c
`define REG_STATUS      8'h10
// ctrl fields
`define CTRL_CLAMP_BIT  0
`define CTRL_VOLUME_BIT 1
// limits fields: min at [11:0], max at [27:16]
`define LIM_MIN_LSB     0
`define LIM_MAX_LSB     16
// surf fields: width at [13:0], height at [29:16]
`define SURF_W_LSB      0
`define SURF_H_LSB      16
// reset values
`define CTRL_RST        32'h0000_0000
`define OFFSET_RST      13'h0000
`define MIN_RST         12'h000
`define MAX_RST         12'hd00
`define BASE_RST        5'h00
`define SURF_DIM_RST    14'h2000
// geometry
`define MAX_LEVELS      14
`define FRAC_BITS       8
`define PIPE_STAGES     3
`endif

// >>> hdl/detail_pkg.sv
package detail_pkg;
    typedef logic signed [12:0] detail_t;  // s4.8 detail value
    typedef logic signed [15:0] coord_t;   // s7.8 fixed coordinate
    typedef enum logic [2:0]
    {
        FACE_POS_X = 3'b000,
        FACE_NEG_X = 3'b001,
        FACE_POS_Y = 3'b010,
        FACE_NEG_Y = 3'b011,
        FACE_POS_Z = 3'b100,
        FACE_NEG_Z = 3'b101
    } face_e;
    typedef enum logic [1:0]
    {
        MSG_SAMPLE    = 2'b00,
        MSG_BIASED    = 2'b01,
        MSG_EXPLICIT  = 2'b10,
        MSG_DIRECT    = 2'b11
    } msg_e;
    typedef struct packed
    {
        msg_e    kind;
        logic    is_cube;
        coord_t  dir_x;
        coord_t  dir_y;
        coord_t  dir_z;
        coord_t  du_dx;
        coord_t  dv_dx;
        coord_t  dq_dx;
        coord_t  du_dy;
        coord_t  dv_dy;
        coord_t  dq_dy;
        detail_t message_detail_offset;
        detail_t message_level;
    } sample_req_s;
    typedef struct packed
    {
        face_e   face;
        detail_t detail;
        logic    magnify;
    } sample_rsp_s;
endpackage : detail_pkg

// >>> hdl/log2_footprint.sv
`timescale 1ns/1ps
`default_nettype none
`include "detail_defs.svh"
// ----------------------------------------------------------------
// half log2 of a squared length, registered
// ----------------------------------------------------------------
module log2_footprint
    import detail_pkg::*;
(
    input  wire logic        core_clk,  // sampler clock
    input  wire logic        sys_rst,   // async reset, high
    input  wire logic [47:0] len_sq,    // squared length, 16 frac bits
    output var  detail_t     log_out    // log2(sqrt(len_sq)) s4.8
);
    // leading one position and 8-bit mantissa fraction
    function automatic detail_t half_log2(input logic [47:0] v);
        integer       i;
        integer       msb;
        logic [47:0]  norm;
        logic [13:0]  full;
        msb  = -1;
        norm = 48'h0;
        full = 14'h0;
        for (i = 0; i < 48; i = i + 1)
        begin
            if (v[i])
                msb = i;
        end
        if (msb < 0)
            half_log2 = 13'sh1000;  // zero length saturates low
        else
        begin
            norm = v << (47 - msb);
            // log2 of len_sq in 6.8, linear mantissa approximation
            full = {6'(msb - 16), norm[46:39]};
            half_log2 = 13'(signed'(full) >>> 1);  // sqrt halves the log
        end
    endfunction : half_log2

    // registered so the main pipeline keeps its stage timing
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            log_out <= 13'sh0000;
        else
            log_out <= half_log2(len_sq);
    end
endmodule : log2_footprint
`default_nettype wire

// >>> hdl/texture_cube_face_and_detail_level.sv
// Contract
// - pick cube face from largest magnitude component and its sign
// - up to fourteen levels, 8192 base down to one texel
// - each level halves u and v, saturating at one texel
// - halving works on odd, non power of two sizes
// - level zero is finest; larger detail means coarser level
// - base level value is the min versus mag crossover point
// - magnification accesses level zero only
// - detail is log2 of larger derivative vector length
// - derivatives are scaled to base level texels
// - third derivative term is zero for 2d surfaces
// - total bias is state offset plus message offset
// - bias always added, no enable
// - bias applied before clamp and min/mag decision
// - optional early clamp between minimum and maximum limits
// - subtract base; non-positive means magnify, detail forced to zero
// - explicit and direct load use state offset plus message level
`timescale 1ns/1ps
`default_nettype none
`include "detail_defs.svh"
module texture_cube_face_and_detail_level
    import detail_pkg::*;
(
    input  wire logic        core_clk,       // sampler clock
    input  wire logic        sys_rst,        // async reset, high
    // avalon-mm slave
    input  wire logic [7:0]  avs_address,    // byte address
    input  wire logic        avs_read,       // read strobe
    input  wire logic        avs_write,      // write strobe
    input  wire logic [31:0] avs_writedata,  // write data
    input  wire logic [3:0]  avs_byteenable, // byte lanes
    output var  logic [31:0] avs_readdata,   // read data
    output logic             avs_waitrequest,// stall
    // request stream
    input  wire logic        req_valid,      // request valid
    output logic             req_ready,      // request accepted
    input  wire sample_req_s req_data,       // request payload
    // response stream
    output var  logic        rsp_valid,      // response valid
    input  wire logic        rsp_ready,      // downstream ready
    output var  sample_rsp_s rsp_data,       // response payload
    output var  logic [3:0]  level_count     // number of levels
);
    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    logic [31:0] ctrl_r;
    detail_t     state_detail_offset_r;
    logic [11:0] minimum_detail_limit_r;
    logic [11:0] maximum_detail_limit_r;
    logic [4:0]  base_level_crossover_r;
    logic [13:0] surf_w_r;
    logic [13:0] surf_h_r;
    logic [31:0] resp_count_r;
    logic        rd_done_r;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0] be);
        integer k;
        merge = old_v;
        for (k = 0; k < 4; k = k + 1)
        begin
            if (be[k])
                merge[8*k +: 8] = new_v[8*k +: 8];
        end
    endfunction : merge

    logic [31:0] lim_word;
    logic [31:0] surf_word;
    logic [31:0] off_word;
    assign lim_word  = {4'h0, maximum_detail_limit_r, 4'h0, minimum_detail_limit_r};
    assign surf_word = {2'h0, surf_h_r, 2'h0, surf_w_r};
    assign off_word  = {11'h0, base_level_crossover_r, 3'h0, state_detail_offset_r};

    logic [31:0] off_mrg;
    logic [31:0] lim_mrg;
    logic [31:0] surf_mrg;
    // byte lanes merged into the current word before the fields are cut out
    assign off_mrg  = merge(off_word, avs_writedata, avs_byteenable);
    assign lim_mrg  = merge(lim_word, avs_writedata, avs_byteenable);
    assign surf_mrg = merge(surf_word, avs_writedata, avs_byteenable);

    // writes take effect in one cycle, never stall
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl_r                 <= `CTRL_RST;
            state_detail_offset_r  <= `OFFSET_RST;
            base_level_crossover_r <= `BASE_RST;
            minimum_detail_limit_r <= `MIN_RST;
            maximum_detail_limit_r <= `MAX_RST;
            surf_w_r               <= `SURF_DIM_RST;
            surf_h_r               <= `SURF_DIM_RST;
        end
        else if (avs_write)
        begin
            case (avs_address)
                `REG_CTRL:
                    ctrl_r <= merge(ctrl_r, avs_writedata, avs_byteenable);
                `REG_OFFSET:
                begin
                    state_detail_offset_r  <= off_mrg[12:0];
                    base_level_crossover_r <= off_mrg[20:16];
                end
                `REG_LIMITS:
                begin
                    minimum_detail_limit_r <= lim_mrg[11:0];
                    maximum_detail_limit_r <= lim_mrg[27:16];
                end
                `REG_SURF:
                begin
                    surf_w_r <= surf_mrg[13:0];
                    surf_h_r <= surf_mrg[29:16];
                end
                default: ;
            endcase
        end
    end

    // reads answer one cycle after the strobe; unmapped reads return zero
    assign avs_waitrequest = avs_read & ~rd_done_r;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_done_r    <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            rd_done_r <= avs_read & ~rd_done_r;
            case (avs_address)
                `REG_CTRL:   avs_readdata <= ctrl_r & 32'h0000_0003;
                `REG_OFFSET: avs_readdata <= off_word;
                `REG_LIMITS: avs_readdata <= lim_word;
                `REG_SURF:   avs_readdata <= surf_word;
                `REG_STATUS: avs_readdata <= resp_count_r;
                default:     avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // level count from surface size
    // ----------------------------------------------------------------
    // halving with round down saturating at one handles odd sizes
    function automatic logic [3:0] levels_of(input logic [13:0] w, input logic [13:0] h);
        integer      n;
        logic [13:0] a;
        logic [13:0] b;
        a = w;
        b = h;
        levels_of = 4'h1;
        for (n = 1; n < `MAX_LEVELS; n = n + 1)
        begin
            if (a > 14'h1 || b > 14'h1)
            begin
                a = (a > 14'h1) ? (a >> 1) : 14'h1;
                b = (b > 14'h1) ? (b >> 1) : 14'h1;
                levels_of = levels_of + 4'h1;
            end
        end
    endfunction : levels_of

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            level_count <= 4'h1;
        else
            level_count <= levels_of(surf_w_r, surf_h_r);
    end

    // ----------------------------------------------------------------
    // stage 1: face select and squared footprints
    // ----------------------------------------------------------------
    logic        stall;
    logic [2:0]  vld_r;
    assign stall     = rsp_valid & ~rsp_ready;
    assign req_ready = ~stall;

    function automatic logic [15:0] mag(input coord_t v);
        mag = v[15] ? 16'(-v) : 16'(v);
    endfunction : mag

    // scale to texels: coord s7.8 times size, keep 8 frac bits
    function automatic logic [23:0] texels(input coord_t v, input logic [13:0] sz);
        logic [29:0] p;
        p = 30'(mag(v)) * 30'(sz);
        texels = p[23:0];
    endfunction : texels

    function automatic logic [47:0] sq(input logic [23:0] v);
        sq = 48'(v) * 48'(v);
    endfunction : sq

    face_e       face_s1_r;
    logic [47:0] lx_s1_r;
    logic [47:0] ly_s1_r;
    msg_e        kind_s1_r;
    detail_t     bias_s1_r;
    detail_t     lvl_s1_r;
    logic        volume;
    assign volume = ctrl_r[`CTRL_VOLUME_BIT];

    // face choice: largest magnitude picks the axis, its sign the face
    function automatic face_e pick_face(input sample_req_s r);
        logic [15:0] ax;
        logic [15:0] ay;
        logic [15:0] az;
        ax = mag(r.dir_x);
        ay = mag(r.dir_y);
        az = mag(r.dir_z);
        if (ax >= ay && ax >= az)
            pick_face = r.dir_x[15] ? FACE_NEG_X : FACE_POS_X;
        else if (ay >= az)
            pick_face = r.dir_y[15] ? FACE_NEG_Y : FACE_POS_Y;
        else
            pick_face = r.dir_z[15] ? FACE_NEG_Z : FACE_POS_Z;
    endfunction : pick_face

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            vld_r     <= 3'h0;
            face_s1_r <= FACE_POS_X;
            lx_s1_r   <= 48'h0;
            ly_s1_r   <= 48'h0;
            kind_s1_r <= MSG_SAMPLE;
            bias_s1_r <= 13'sh0000;
            lvl_s1_r  <= 13'sh0000;
        end
        else if (!stall)
        begin
            vld_r     <= {vld_r[1:0], req_valid};
            face_s1_r <= req_data.is_cube ? pick_face(req_data) : FACE_POS_X;
            // the depth term only counts for volume surfaces
            lx_s1_r   <= sq(texels(req_data.du_dx, surf_w_r))
                       + sq(texels(req_data.dv_dx, surf_h_r))
                       + (volume ? sq(texels(req_data.dq_dx, surf_w_r)) : 48'h0);
            ly_s1_r   <= sq(texels(req_data.du_dy, surf_w_r))
                       + sq(texels(req_data.dv_dy, surf_h_r))
                       + (volume ? sq(texels(req_data.dq_dy, surf_w_r)) : 48'h0);
            kind_s1_r <= req_data.kind;
            // message offset only honoured for the biased message
            bias_s1_r <= (req_data.kind == MSG_BIASED) ? req_data.message_detail_offset
                                                       : 13'sh0000;
            lvl_s1_r  <= req_data.message_level;
        end
    end

    // ----------------------------------------------------------------
    // stage 2: log2 of the larger footprint
    // ----------------------------------------------------------------
    detail_t     log_s2;
    face_e       face_s2_r;
    msg_e        kind_s2_r;
    detail_t     bias_s2_r;
    detail_t     lvl_s2_r;
    logic [47:0] big_len;
    assign big_len = (lx_s1_r > ly_s1_r) ? lx_s1_r : ly_s1_r;

    logic [47:0] len_s2_r;
    logic [47:0] log_in;
    // log unit has no hold: under a stall it re-reads the stage 2 length,
    // else it would run ahead to the stage 1 item and pair wrongly
    assign log_in = stall ? len_s2_r : big_len;

    log2_footprint u_log
    (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .len_sq   (log_in),
        .log_out  (log_s2)
    );

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            face_s2_r <= FACE_POS_X;
            kind_s2_r <= MSG_SAMPLE;
            bias_s2_r <= 13'sh0000;
            lvl_s2_r  <= 13'sh0000;
            len_s2_r  <= 48'h0;
        end
        else if (!stall)
        begin
            len_s2_r  <= big_len;
            face_s2_r <= face_s1_r;
            kind_s2_r <= kind_s1_r;
            bias_s2_r <= bias_s1_r;
            lvl_s2_r  <= lvl_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // stage 3: bias, clamp, min/mag
    // ----------------------------------------------------------------
    function automatic detail_t sat(input logic signed [14:0] v);
        if (v > 15'sh0fff)
            sat = 13'sh0fff;
        else if (v < -15'sh1000)
            sat = 13'sh1000;
        else
            sat = v[12:0];
    endfunction : sat

    detail_t                biased;
    detail_t                clamped;
    logic signed [14:0]     rel;
    logic                   is_mag;
    always_comb
    begin
        // bias always applied, no enable exists
        if (kind_s2_r == MSG_EXPLICIT || kind_s2_r == MSG_DIRECT)
            biased = sat(15'(state_detail_offset_r) + 15'(lvl_s2_r));
        else
            biased = sat(15'(log_s2) + 15'(state_detail_offset_r)
                         + 15'(bias_s2_r));
        clamped = biased;
        if (ctrl_r[`CTRL_CLAMP_BIT])
        begin
            if (clamped > signed'({1'b0, maximum_detail_limit_r}))
                clamped = signed'({1'b0, maximum_detail_limit_r});
            if (clamped < signed'({1'b0, minimum_detail_limit_r}))
                clamped = signed'({1'b0, minimum_detail_limit_r});
        end
        // base is u4.1, shift to 8 fractional bits
        rel    = 15'(clamped) - 15'({base_level_crossover_r, 7'h00});
        is_mag = (rel <= 15'sh0000);
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rsp_data  <= '{face: FACE_POS_X, detail: 13'sh0000, magnify: 1'b0};
            rsp_valid <= 1'b0;
        end
        else if (!stall)
        begin
            rsp_valid        <= vld_r[1];
            rsp_data.face    <= face_s2_r;
            // magnify selects level zero: coarser levels only when minifying
            rsp_data.detail  <= is_mag ? 13'sh0000 : clamped;
            rsp_data.magnify <= is_mag;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            resp_count_r <= 32'h0;
        else if (rsp_valid && rsp_ready)
            resp_count_r <= resp_count_r + 32'h1;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence take_s;
        req_valid && req_ready;
    endsequence
    property latency_p;
        @(posedge core_clk) disable iff (sys_rst)
        take_s ##1 !stall ##1 !stall ##1 !stall |-> rsp_valid;
    endproperty
    pipe_latency_a: assert property (latency_p)
        else $error("response missing after fixed latency");
    mag_zero_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        rsp_valid && rsp_data.magnify |-> rsp_data.detail == 13'sh0000)
        else $error("magnify with nonzero detail");
    ready_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        req_ready == !(rsp_valid && !rsp_ready))
        else $error("ready does not follow stall");
    hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("response changed under stall");
    clamp_hi_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        ctrl_r[`CTRL_CLAMP_BIT] |-> clamped <= signed'({1'b0, maximum_detail_limit_r})
        || minimum_detail_limit_r > maximum_detail_limit_r)
        else $error("clamp exceeded maximum");
    face_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        req_valid && req_ready && req_data.is_cube && !req_data.dir_x[15]
        && req_data.dir_x > mag(req_data.dir_y)
        && req_data.dir_x > mag(req_data.dir_z) && !stall |=> face_s1_r == FACE_POS_X)
        else $error("wrong cube face");
    bias_msg_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !stall && req_data.kind != MSG_BIASED |=> bias_s1_r == 13'sh0000)
        else $error("message offset leaked");
    rd_wait_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("read stalled too long");
endmodule : texture_cube_face_and_detail_level
`default_nettype wire

// >>> verification/shader_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// shader core side: issues sample messages
// ------------------------------------------------------------
module shader_core_model
    import detail_pkg::*;
(
    input  wire logic        core_clk,   // sampler clock
    output var  logic        req_valid,  // request valid
    input  wire logic        req_ready,  // request accepted
    output var  sample_req_s req_data    // request payload
);
    // idle until the first message
    initial
    begin
        req_valid = 1'b0;
        req_data  = '0;
    end
    // one message per call, held until the block takes it
    task automatic send(input sample_req_s r);
        sample_req_s m;
        m = r;
        // only biased messages may carry a message offset
        if (m.kind != MSG_BIASED)
            m.message_detail_offset = '0;
        @(posedge core_clk);
        req_valid <= 1'b1;
        req_data  <= m;
        do
            @(posedge core_clk);
        while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        // released payload flips so a stale value never passes as good
        req_data  <= ~m;
    endtask : send
endmodule : shader_core_model
`default_nettype wire

// >>> verification/texture_cube_face_and_detail_level_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// face and detail level bench
// ------------------------------------------------------------
module texture_cube_face_and_detail_level_tb
    import detail_pkg::*;
;
    logic        core_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic        req_valid, req_ready, rsp_valid, rsp_ready;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable, level_count;
    sample_req_s req_data;
    sample_rsp_s rsp_data;
    sample_rsp_s exp_q[$];
    int          mismatches, n_checks, n_rsp;
    // cube vectors, major component already 1.0
    coord_t      cx[6] = '{16'h0100, 16'hff00, 16'h0080, 16'h0080, 16'h0080, 16'hff80};
    coord_t      cy[6] = '{16'h0080, 16'h0080, 16'h0100, 16'hff00, 16'hff80, 16'h0080};
    coord_t      cz[6] = '{16'hff80, 16'h0080, 16'hff80, 16'h0080, 16'h0100, 16'hff00};
    int          sw[4] = '{100, 1, 8192, 5};
    int          sh[4] = '{6, 1, 3, 12};

    texture_cube_face_and_detail_level u_texture_cube_face_and_detail_level (
        .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .req_valid(req_valid), .req_ready(req_ready),
        .req_data(req_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
        .rsp_data(rsp_data), .level_count(level_count));
    shader_core_model u_shader_core_model (
        .core_clk(core_clk), .req_valid(req_valid), .req_ready(req_ready),
        .req_data(req_data));

    // 200 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word
    task automatic cmp_rsp(input sample_rsp_s got, input sample_rsp_s exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_rsp
    // avalon master: hold until waitrequest is seen low
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        do
            @(posedge core_clk);
        while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask : reg_wr
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do
            @(posedge core_clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        cmp_word(rd, exp);
    endtask : reg_chk
    function automatic sample_req_s mk(msg_e k, logic c, coord_t x, coord_t y, coord_t z,
                                       coord_t dux, coord_t dvy, coord_t dqx,
                                       detail_t mo, detail_t ml);
        mk = '0;
        mk.kind = k;
        mk.is_cube = c;
        mk.dir_x = x;
        mk.dir_y = y;
        mk.dir_z = z;
        mk.du_dx = dux;
        mk.dv_dy = dvy;
        mk.dq_dx = dqx;
        mk.message_detail_offset = mo;
        mk.message_level = ml;
    endfunction : mk
    task automatic go(input sample_req_s r, input face_e f, input detail_t d, input logic m);
        exp_q.push_back('{f, d, m});
        u_shader_core_model.send(r);
    endtask : go
    task automatic drain(input string s);
        for (int i = 0; i < 60 && exp_q.size() != 0; i++)
            @(posedge core_clk);
        cmp_word(exp_q.size(), 0);
        $display("test %s done", s);
    endtask : drain
    function automatic logic [3:0] nlev(int w, int h);
        int m;
        m = (w > h) ? w : h;
        nlev = 4'h1;
        // odd sizes round down, one texel is the floor
        while (m > 1)
        begin
            m = m / 2;
            nlev++;
        end
    endfunction : nlev
    // response checker, in order
    always @(posedge core_clk)
        if (rsp_valid === 1'b1 && rsp_ready === 1'b1)
        begin
            cmp_rsp(rsp_data, exp_q.pop_front());
            n_rsp++;
        end
    // watchdog, tests need well under 4000 cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        final_report();
    end
    // main sequence
    initial
    begin
        sys_rst = 1'b1;
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        rsp_ready = 1'b1;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        reg_chk(8'h00, 32'h0);
        reg_chk(8'h08, 32'h0d00_0000);
        reg_chk(8'h0c, 32'h2000_2000);
        reg_chk(8'h20, 32'h0);
        cmp_word(level_count, 32'd14);
        for (int i = 0; i < 6; i++)
            go(mk(MSG_SAMPLE, 1, cx[i], cy[i], cz[i], 1, 0, 0, 0, 0), face_e'(i), 13'h500, 0);
        go(mk(MSG_SAMPLE, 0, 0, 0, 0, 1, 4, 0, 0, 0), FACE_POS_X, 13'h700, 0);
        go(mk(MSG_SAMPLE, 0, 0, 0, 0, 0, 0, 16'h10, 0, 0), FACE_POS_X, 13'h0, 1);
        reg_wr(8'h00, 32'h2);
        go(mk(MSG_SAMPLE, 0, 0, 0, 0, 0, 0, 16'h10, 0, 0), FACE_POS_X, 13'h900, 0);
        reg_wr(8'h00, 32'h0);
        drain("faces");
        reg_wr(8'h04, 32'h100);
        reg_chk(8'h04, 32'h100);
        go(mk(MSG_BIASED, 0, 0, 0, 0, 1, 0, 0, 13'h80, 0), FACE_POS_X, 13'h680, 0);
        go(mk(MSG_SAMPLE, 0, 0, 0, 0, 1, 0, 0, 13'h80, 0), FACE_POS_X, 13'h600, 0);
        go(mk(MSG_EXPLICIT, 0, 0, 0, 0, 1, 0, 0, 0, 13'h200), FACE_POS_X, 13'h300, 0);
        go(mk(MSG_DIRECT, 0, 0, 0, 0, 1, 0, 0, 0, 13'h400), FACE_POS_X, 13'h500, 0);
        drain("bias");
        reg_wr(8'h04, 32'h0);
        reg_wr(8'h08, 32'h0300_0100);
        reg_wr(8'h00, 32'h1);
        go(mk(MSG_SAMPLE, 0, 0, 0, 0, 1, 0, 0, 0, 0), FACE_POS_X, 13'h300, 0);
        go(mk(MSG_SAMPLE, 0, 0, 0, 0, 0, 0, 16'h10, 0, 0), FACE_POS_X, 13'h100, 0);
        reg_wr(8'h00, 32'h0);
        go(mk(MSG_SAMPLE, 0, 0, 0, 0, 1, 0, 0, 0, 0), FACE_POS_X, 13'h500, 0);
        reg_wr(8'h08, 32'h0d00_0000);
        reg_wr(8'h04, 32'h000c_0000);
        go(mk(MSG_SAMPLE, 0, 0, 0, 0, 2, 0, 0, 0, 0), FACE_POS_X, 13'h0, 1);
        reg_wr(8'h04, 32'h0000_1a00);
        go(mk(MSG_SAMPLE, 0, 0, 0, 0, 1, 0, 0, 0, 0), FACE_POS_X, 13'h0, 1);
        reg_wr(8'h04, 32'h0);
        drain("clamp and crossover");
        rsp_ready <= 1'b0;
        fork
            for (int i = 0; i < 5; i++)
                go(mk(MSG_SAMPLE, 0, 0, 0, 0, 16'(1 << i), 0, 0, 0, 0), FACE_POS_X,
                   13'(32'h500 + (i << 8)), 0);
            begin
                repeat (20) @(posedge core_clk);
                cmp_word(rsp_valid, 32'h1);
                rsp_ready <= 1'b1;
            end
        join
        drain("stall");
        reg_wr(8'h10, 32'hffff_ffff);
        reg_chk(8'h10, n_rsp);
        for (int i = 0; i < 4; i++)
        begin
            reg_wr(8'h0c, (sh[i] << 16) | sw[i]);
            repeat (2) @(posedge core_clk);
            cmp_word(level_count, nlev(sw[i], sh[i]));
        end
        $display("test levels done");
        final_report();
    end
endmodule : texture_cube_face_and_detail_level_tb
`default_nettype wire
